//--- hw/flash_cmd_pkg.sv
// Package: command codes, unlock addresses and bus timing for the flash host
package flash_cmd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 50;
  // Unlock addresses (word mode)
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [ADDR_W-1:0] DONT_CARE_ADDR = 20'h00000;
  // Data codes
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_BYPASS_ENTER = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_REGION_ENTER = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_REGION_EXIT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_REGION_EXIT4 = 16'h0000;
  // Serial-number region size in bytes
  localparam int SERIAL_BYTES = 16;
  // Sector erase window, ns; host keeps gaps below it with margin
  localparam int ERASE_WINDOW_NS = 50000;
  localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_NS * CLK_MHZ / 1000;
  // Host limits extra sector gaps to half the window
  localparam int ERASE_GAP_CYC = ERASE_WINDOW_CYC / 2;
  // Write strobe phase lengths in clock cycles
  localparam int SETUP_CYC = 2;
  localparam int PULSE_CYC = 3;
  localparam int HOLD_CYC = 2;
  localparam int PHASE_W = 3;
  // Host operation codes on op_i
  typedef enum logic [2:0] {
    OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_EXIT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_REGION_ENTER, OP_REGION_EXIT
  } op_t;
endpackage

//--- hw/flash_bus_write.sv
// One bus write cycle: chip select and write strobe with set-up and hold
`timescale 1ns/1ns
`default_nettype none
module flash_bus_write (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic chip_sel_n_o,
  output logic write_n_o,
  output logic [flash_cmd_pkg::ADDR_W-1:0] addr_o,
  output logic [flash_cmd_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o
);
  import flash_cmd_pkg::*;
  typedef enum {W_IDLE, W_SETUP, W_PULSE, W_HOLD} wstate_t;
  wstate_t state_reg;
  logic [PHASE_W-1:0] cnt_reg;

  // Phase sequencer; address set before the falling strobe, data held past rise
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= W_IDLE;
      cnt_reg <= '0;
      chip_sel_n_o <= 1'b1;
      write_n_o <= 1'b1;
      addr_o <= '0;
      data_o <= '0;
      data_oe_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      case (state_reg)
        W_IDLE: begin
          if (start_i) begin
            addr_o <= addr_i;
            data_o <= data_i;
            data_oe_o <= 1'b1;
            chip_sel_n_o <= 1'b0;
            cnt_reg <= PHASE_W'(SETUP_CYC - 1);
            state_reg <= W_SETUP;
          end
        end
        W_SETUP: begin
          if (cnt_reg == '0) begin
            write_n_o <= 1'b0;
            cnt_reg <= PHASE_W'(PULSE_CYC - 1);
            state_reg <= W_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        W_PULSE: begin
          if (cnt_reg == '0) begin
            write_n_o <= 1'b1;
            cnt_reg <= PHASE_W'(HOLD_CYC - 1);
            state_reg <= W_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        W_HOLD: begin
          if (cnt_reg == '0) begin
            chip_sel_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            done_o <= 1'b1;
            state_reg <= W_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= W_IDLE;
      endcase
    end
  end

  assign busy_o = (state_reg != W_IDLE);
endmodule
`default_nettype wire

//--- hw/flash_cmd_host.sv
// Host-side command sequencer driving a parallel NOR flash over its pins
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] op_i,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] data_i,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] old_data_i,
  input wire logic byte_mode_i,
  input wire logic more_sector_i,
  output logic done_o,
  output logic error_o,
  output logic bypass_mode_o,
  output logic region_mode_o,
  output logic width_word_o,
  input wire logic ready_busy_n,
  output logic chip_sel_n_o,
  output logic write_n_o,
  output logic [flash_cmd_pkg::ADDR_W-1:0] flash_addr_o,
  output logic [flash_cmd_pkg::DATA_W-1:0] flash_data_o,
  output logic flash_data_oe_o
);
  import flash_cmd_pkg::*;

  typedef enum {S_IDLE, S_SEND, S_WAIT, S_WINDOW, S_BUSY} state_t;
  state_t state_reg;
  logic [2:0] op_reg;
  logic [2:0] step_reg;
  logic [2:0] last_step;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [15:0] timer_reg;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_start, wr_busy, wr_done;
  logic bad_req;
  logic expect_busy;

  // Legal requests depend on the current mode
  always_comb begin
    bad_req = 1'b0;
    if (bypass_mode_o) begin
      bad_req = !(op_i == OP_BYPASS_PROGRAM || op_i == OP_BYPASS_EXIT);
    end else begin
      if (op_i == OP_BYPASS_PROGRAM || op_i == OP_BYPASS_EXIT) begin
        bad_req = 1'b1;
      end
      if (op_i == OP_BYPASS_ENTER && region_mode_o) begin
        bad_req = 1'b1;
      end
    end
    if ((op_i == OP_PROGRAM || op_i == OP_BYPASS_PROGRAM) &&
        ((~old_data_i & data_i) != '0)) begin
      bad_req = 1'b1;
    end
  end

  // Number of writes per operation, less one
  always_comb begin
    case (op_t'(op_reg))
      OP_PROGRAM: last_step = 3'd3;
      OP_BYPASS_ENTER: last_step = 3'd2;
      OP_BYPASS_PROGRAM: last_step = 3'd1;
      OP_BYPASS_EXIT: last_step = 3'd1;
      OP_CHIP_ERASE: last_step = 3'd5;
      OP_SECTOR_ERASE: last_step = 3'd5;
      OP_REGION_ENTER: last_step = 3'd2;
      OP_REGION_EXIT: last_step = 3'd3;
      default: last_step = 3'd0;
    endcase
  end

  // Address and data of the current write, exact codes only
  always_comb begin
    wr_addr = UNLOCK_ADDR1;
    wr_data = UNLOCK_DATA1;
    if (step_reg == 3'd1 || step_reg == 3'd4) begin
      wr_addr = UNLOCK_ADDR2;
      wr_data = UNLOCK_DATA2;
    end
    case (op_t'(op_reg))
      OP_PROGRAM: begin
        if (step_reg == 3'd2) wr_data = CMD_PROGRAM;
        if (step_reg == 3'd3) begin
          wr_addr = addr_reg;
          wr_data = data_reg;
        end
      end
      OP_BYPASS_ENTER: if (step_reg == 3'd2) wr_data = CMD_BYPASS_ENTER;
      OP_BYPASS_PROGRAM: begin
        wr_addr = (step_reg == 3'd0) ? DONT_CARE_ADDR : addr_reg;
        wr_data = (step_reg == 3'd0) ? CMD_PROGRAM : data_reg;
      end
      OP_BYPASS_EXIT: begin
        wr_addr = DONT_CARE_ADDR;
        wr_data = (step_reg == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_RESET;
      end
      OP_CHIP_ERASE: begin
        if (step_reg == 3'd2) wr_data = CMD_ERASE_SETUP;
        if (step_reg == 3'd5) wr_data = CMD_CHIP_ERASE;
      end
      OP_SECTOR_ERASE: begin
        if (step_reg == 3'd2) wr_data = CMD_ERASE_SETUP;
        if (step_reg == 3'd5) begin
          wr_addr = addr_reg;
          wr_data = CMD_SECTOR_ERASE;
        end
      end
      OP_REGION_ENTER: if (step_reg == 3'd2) wr_data = CMD_REGION_ENTER;
      OP_REGION_EXIT: begin
        if (step_reg == 3'd2) wr_data = CMD_REGION_EXIT;
        if (step_reg == 3'd3) begin
          wr_addr = DONT_CARE_ADDR;
          wr_data = CMD_REGION_EXIT4;
        end
      end
      default: wr_data = UNLOCK_DATA1;
    endcase
  end

  // Program and chip erase ops start an embedded algorithm; sector erase first runs its window
  assign expect_busy = (op_reg == OP_PROGRAM) ||
                       (op_reg == OP_BYPASS_PROGRAM) ||
                       (op_reg == OP_CHIP_ERASE);

  assign wr_start = (state_reg == S_SEND) && !wr_busy;
  // New requests only while idle and device ready
  assign req_ready_o = (state_reg == S_IDLE) && ready_busy_n;
  assign width_word_o = !byte_mode_i;

  // Main sequencer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= S_IDLE;
      op_reg <= 3'd0;
      step_reg <= 3'd0;
      addr_reg <= '0;
      data_reg <= '0;
      timer_reg <= '0;
      done_o <= 1'b0;
      error_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      error_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            if (bad_req) begin
              error_o <= 1'b1;
              done_o <= 1'b1;
            end else begin
              op_reg <= op_i;
              addr_reg <= addr_i;
              data_reg <= data_i;
              step_reg <= 3'd0;
              state_reg <= S_SEND;
            end
          end
        end
        S_SEND: if (wr_start) state_reg <= S_WAIT;
        S_WAIT: begin
          if (wr_done) begin
            if (step_reg == last_step) begin
              timer_reg <= '0;
              if (op_reg == OP_SECTOR_ERASE) begin
                state_reg <= S_WINDOW;
              end else if (expect_busy) begin
                state_reg <= S_BUSY;
              end else begin
                done_o <= 1'b1;
                state_reg <= S_IDLE;
              end
            end else begin
              step_reg <= step_reg + 3'd1;
              state_reg <= S_SEND;
            end
          end
        end
        S_WINDOW: begin
          timer_reg <= timer_reg + 16'd1;
          if (more_sector_i && timer_reg < 16'(ERASE_GAP_CYC)) begin
            addr_reg <= addr_i;
            step_reg <= 3'd5;
            state_reg <= S_SEND;
          end else if (timer_reg >= 16'(ERASE_WINDOW_CYC)) begin
            timer_reg <= '0;
            state_reg <= S_BUSY;
          end
        end
        S_BUSY: begin
          // Settle a few cycles so busy has time to assert
          if (timer_reg < 16'(SETUP_CYC + HOLD_CYC)) begin
            timer_reg <= timer_reg + 16'd1;
          end else if (ready_busy_n) begin
            done_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Mode tracking for bypass and serial-number region
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bypass_mode_o <= 1'b0;
      region_mode_o <= 1'b0;
    end else if (ce_i && state_reg == S_WAIT && wr_done &&
                 step_reg == last_step) begin
      if (op_reg == OP_BYPASS_ENTER) bypass_mode_o <= 1'b1;
      if (op_reg == OP_BYPASS_EXIT) bypass_mode_o <= 1'b0;
      if (op_reg == OP_REGION_ENTER) region_mode_o <= 1'b1;
      if (op_reg == OP_REGION_EXIT) region_mode_o <= 1'b0;
    end
  end

  flash_bus_write u_write (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .start_i(wr_start),
    .addr_i(wr_addr),
    .data_i(wr_data),
    .busy_o(wr_busy),
    .done_o(wr_done),
    .chip_sel_n_o(chip_sel_n_o),
    .write_n_o(write_n_o),
    .addr_o(flash_addr_o),
    .data_o(flash_data_o),
    .data_oe_o(flash_data_oe_o)
  );
endmodule
`default_nettype wire

//--- dv/flash_cmd_host_assertions.sv
// Checker: strobe timing and mode relations of the flash command host
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_assertions (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic req_ready_o,
  input wire logic byte_mode_i,
  input wire logic done_o,
  input wire logic error_o,
  input wire logic bypass_mode_o,
  input wire logic region_mode_o,
  input wire logic width_word_o,
  input wire logic ready_busy_n,
  input wire logic chip_sel_n_o,
  input wire logic write_n_o,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] flash_addr_o,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] flash_data_o,
  input wire logic flash_data_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Write strobe framing on the pins
  AST_WE_IN_CS:
    assert property (!write_n_o |-> !chip_sel_n_o && flash_data_oe_o)
    else $error("write strobe outside select");
  AST_WE_PULSE:
    assert property ($fell(write_n_o) |-> !write_n_o [*3] ##1 write_n_o)
    else $error("write strobe width wrong");
  AST_SETUP:
    assert property ($fell(write_n_o) |->
      !$past(chip_sel_n_o, 2) && $stable(flash_addr_o))
    else $error("address set-up too short");
  AST_HOLD:
    assert property ($rose(write_n_o) |->
      (!chip_sel_n_o && $stable(flash_data_o)) [*2])
    else $error("data hold too short");
  // Completion, refusal and busy relations
  AST_ERR_DONE:
    assert property (error_o |-> done_o)
    else $error("error without done");
  AST_DONE_PULSE:
    assert property (done_o |-> chip_sel_n_o ##1 !done_o)
    else $error("done not a released pulse");
  AST_NO_WR_BUSY:
    assert property (!ready_busy_n |-> write_n_o && !req_ready_o)
    else $error("activity while device busy");
  AST_REGION_BYPASS:
    assert property (region_mode_o |-> !bypass_mode_o)
    else $error("bypass while region mapped");
  AST_WIDTH:
    assert property (width_word_o == !byte_mode_i)
    else $error("width select wrong");
endmodule
bind flash_cmd_host flash_cmd_host_assertions CHK (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_ready_o(req_ready_o),
  .byte_mode_i(byte_mode_i), .done_o(done_o), .error_o(error_o),
  .bypass_mode_o(bypass_mode_o), .region_mode_o(region_mode_o),
  .width_word_o(width_word_o), .ready_busy_n(ready_busy_n),
  .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o),
  .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
  .flash_data_oe_o(flash_data_oe_o));
`default_nettype wire

//--- dv/flash_dev_model.sv
// Behavioural flash device: logs writes, runs busy and erase window
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
  import flash_cmd_pkg::*;
#(
  parameter int BUSY_CYC = 30,
  parameter int WIN_CYC = 2500
) (
  input wire logic clock_i,
  input wire logic chip_sel_n_i,
  input wire logic write_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic ready_busy_n
);
  logic we_q = 1'b1;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] prev;
  logic [35:0] log_q[$];
  int busy_cnt = 0;
  int win_cnt = 0;
  int n_ops = 0;
  assign ready_busy_n = (busy_cnt == 0);
  // Pin decode: address on strobe fall, data on strobe rise
  always @(posedge clock_i) begin
    we_q <= write_n_i;
    if (!write_n_i && we_q && !chip_sel_n_i) addr_q <= addr_i;
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    if (win_cnt == 1) begin
      busy_cnt <= BUSY_CYC;
      n_ops <= n_ops + 1;
    end
    if (win_cnt > 0) win_cnt <= win_cnt - 1;
    if (write_n_i && !we_q && !chip_sel_n_i) begin
      log_q.push_back({addr_q, data_i});
      prev <= data_i;
      if (busy_cnt == 0 && (prev == CMD_PROGRAM ||
          (prev == UNLOCK_DATA2 && data_i == CMD_CHIP_ERASE))) begin
        busy_cnt <= BUSY_CYC;
        n_ops <= n_ops + 1;
        prev <= '0;
      end else if (busy_cnt == 0 && data_i == CMD_SECTOR_ERASE)
        win_cnt <= WIN_CYC;
      else if (win_cnt > 0)
        win_cnt <= 0;
    end
  end
endmodule
`default_nettype wire

//--- dv/flash_cmd_host_tb_top.sv
// Testbench: command sequences of the flash host against a device model
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_tb_top;
  import flash_cmd_pkg::*;
  logic clock_i, sys_rst_i, ce_i, req_valid_i, byte_mode_i, more_sector_i;
  logic [2:0] op_i;
  logic [ADDR_W-1:0] addr_i, flash_addr_o;
  logic [DATA_W-1:0] data_i, old_data_i, flash_data_o;
  logic req_ready_o, done_o, error_o, bypass_mode_o, region_mode_o;
  logic width_word_o, ready_busy_n, chip_sel_n_o, write_n_o, flash_data_oe_o;
  logic [35:0] exp_q[$];
  int n_errors = 0;
  int checked = 0;
  flash_cmd_host DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .op_i(op_i), .addr_i(addr_i), .data_i(data_i), .old_data_i(old_data_i),
    .byte_mode_i(byte_mode_i), .more_sector_i(more_sector_i),
    .done_o(done_o), .error_o(error_o), .bypass_mode_o(bypass_mode_o),
    .region_mode_o(region_mode_o), .width_word_o(width_word_o),
    .ready_busy_n(ready_busy_n), .chip_sel_n_o(chip_sel_n_o),
    .write_n_o(write_n_o), .flash_addr_o(flash_addr_o),
    .flash_data_o(flash_data_o), .flash_data_oe_o(flash_data_oe_o));
  flash_dev_model DEV (.clock_i(clock_i), .chip_sel_n_i(chip_sel_n_o),
    .write_n_i(write_n_o), .addr_i(flash_addr_o), .data_i(flash_data_o),
    .ready_busy_n(ready_busy_n));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic give_verdict();
    $display("Checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] e,
                     input logic [35:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // Expected write list, then comparison against the device log
  task automatic ew(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    exp_q.push_back({a, d});
  endtask
  task automatic unl();
    ew(UNLOCK_ADDR1, UNLOCK_DATA1);
    ew(UNLOCK_ADDR2, UNLOCK_DATA2);
  endtask
  task automatic chk_seq();
    chk("write count", 36'(exp_q.size()), 36'(DEV.log_q.size()));
    foreach (exp_q[k])
      if (k < DEV.log_q.size()) chk("bus write", exp_q[k], DEV.log_q[k]);
    exp_q.delete();
    DEV.log_q.delete();
  endtask
  // A used-up bound counts as a mismatch and ends the run
  task automatic wait_neg(input int lim, input logic cond);
    if (lim == 0 && !cond) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // One request: held until taken, then wait for done
  task automatic req(input op_t op, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] old,
    output logic err);
    int i;
    @(negedge clock_i);
    op_i = op;
    addr_i = a;
    data_i = d;
    old_data_i = old;
    req_valid_i = 1'b1;
    for (i = 200; i > 0 && req_ready_o !== 1'b1; i--) @(negedge clock_i);
    wait_neg(i, req_ready_o === 1'b1);
    @(negedge clock_i);
    req_valid_i = 1'b0;
    for (i = 9000; i > 0 && done_o !== 1'b1; i--) @(negedge clock_i);
    wait_neg(i, done_o === 1'b1);
    err = error_o;
  endtask
  task automatic t_program();
    logic e;
    int n;
    for (int b = 0; b < 2; b++) begin
      n = DEV.n_ops;
      byte_mode_i = b[0];
      unl();
      ew(UNLOCK_ADDR1, CMD_PROGRAM);
      ew(b[0] ? 20'hf2345 : 20'h12345, 16'h5a0f);
      req(OP_PROGRAM, b[0] ? 20'hf2345 : 20'h12345, 16'h5a0f, 16'hffff, e);
      chk("width word", 36'(!b[0]), 36'(width_word_o));
      chk("program error", 36'h0, 36'(e));
      chk_seq();
      chk("busy runs", 36'(n + 1), 36'(DEV.n_ops));
      chk("ready after", 36'h1, 36'(ready_busy_n));
    end
    req(OP_PROGRAM, 20'h00100, 16'h0001, 16'h0000, e);
    chk("zero to one refused", 36'h1, 36'(e));
    chk_seq();
  endtask
  // Clock-enable freeze inside a write, then a reset in mid-sequence
  task automatic t_reset();
    @(negedge clock_i);
    op_i = OP_PROGRAM;
    addr_i = 20'h00400;
    data_i = 16'h0f0f;
    old_data_i = 16'hffff;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    @(negedge clock_i);
    ce_i = 1'b0;
    repeat (10) @(negedge clock_i);
    chk("frozen select", 36'h0, 36'(chip_sel_n_o));
    chk("frozen strobe", 36'h1, 36'(write_n_o));
    chk("frozen address", 36'(UNLOCK_ADDR1), 36'(flash_addr_o));
    ce_i = 1'b1;
    repeat (12) @(negedge clock_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("reset select", 36'h1, 36'(chip_sel_n_o));
    chk("reset strobe", 36'h1, 36'(write_n_o));
    chk("reset data enable", 36'h0, 36'(flash_data_oe_o));
    sys_rst_i = 1'b0;
    chk("reset ready", 36'h1, 36'(req_ready_o));
    DEV.log_q.delete();
  endtask
  task automatic t_bypass();
    logic e;
    req(OP_BYPASS_PROGRAM, 20'h00200, 16'h1234, 16'hffff, e);
    chk("bypass prog outside", 36'h1, 36'(e));
    unl();
    ew(UNLOCK_ADDR1, CMD_BYPASS_ENTER);
    req(OP_BYPASS_ENTER, 20'h0, 16'h0, 16'h0, e);
    chk("bypass mode on", 36'h1, 36'(bypass_mode_o));
    ew(DONT_CARE_ADDR, CMD_PROGRAM);
    ew(20'h00200, 16'h1234);
    req(OP_BYPASS_PROGRAM, 20'h00200, 16'h1234, 16'hffff, e);
    chk("bypass prog error", 36'h0, 36'(e));
    req(OP_CHIP_ERASE, 20'h0, 16'h0, 16'h0, e);
    chk("erase in bypass", 36'h1, 36'(e));
    ew(DONT_CARE_ADDR, CMD_BYPASS_EXIT1);
    ew(DONT_CARE_ADDR, CMD_RESET);
    req(OP_BYPASS_EXIT, 20'h0, 16'h0, 16'h0, e);
    chk("bypass mode off", 36'h0, 36'(bypass_mode_o));
    chk_seq();
  endtask
  task automatic t_erase();
    logic e;
    int n;
    n = DEV.n_ops;
    unl();
    ew(UNLOCK_ADDR1, CMD_ERASE_SETUP);
    unl();
    ew(UNLOCK_ADDR1, CMD_CHIP_ERASE);
    req(OP_CHIP_ERASE, 20'h0, 16'h0, 16'h0, e);
    chk_seq();
    chk("chip erase busy", 36'(n + 1), 36'(DEV.n_ops));
    unl();
    ew(UNLOCK_ADDR1, CMD_ERASE_SETUP);
    unl();
    ew(20'h10000, CMD_SECTOR_ERASE);
    ew(20'h30000, CMD_SECTOR_ERASE);
    fork
      req(OP_SECTOR_ERASE, 20'h10000, 16'h0, 16'h0, e);
      begin : add_sector
        int i;
        for (i = 800; i > 0 && DEV.log_q.size() < 6; i--)
          @(negedge clock_i);
        addr_i = 20'h30000;
        more_sector_i = 1'b1;
        for (i = 800; i > 0 && DEV.log_q.size() < 7; i--)
          @(negedge clock_i);
        more_sector_i = 1'b0;
      end
    join
    chk_seq();
    chk("sector erase busy", 36'(n + 2), 36'(DEV.n_ops));
  endtask
  task automatic t_region();
    logic e;
    unl();
    ew(UNLOCK_ADDR1, CMD_REGION_ENTER);
    req(OP_REGION_ENTER, 20'h0, 16'h0, 16'h0, e);
    chk("region on", 36'h1, 36'(region_mode_o));
    chk_seq();
    req(OP_BYPASS_ENTER, 20'h0, 16'h0, 16'h0, e);
    chk("bypass in region", 36'h1, 36'(e));
    unl();
    ew(UNLOCK_ADDR1, CMD_REGION_EXIT);
    ew(DONT_CARE_ADDR, CMD_REGION_EXIT4);
    req(OP_REGION_EXIT, 20'h0, 16'h0, 16'h0, e);
    chk("region off", 36'h0, 36'(region_mode_o));
    chk_seq();
  endtask
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    req_valid_i = 1'b0;
    op_i = '0;
    addr_i = '0;
    data_i = '0;
    old_data_i = '0;
    byte_mode_i = 1'b0;
    more_sector_i = 1'b0;
    repeat (8) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_program();
    t_reset();
    t_bypass();
    t_erase();
    t_region();
    give_verdict();
  end
endmodule
`default_nettype wire
